// >>> inc/bdwt_params.svh
`ifndef BDWT_PARAMS_SVH
`define BDWT_PARAMS_SVH
`define BDWT_CLK_NS 40
`define BDWT_CEIL(t) (((t) + `BDWT_CLK_NS - 1) / `BDWT_CLK_NS)
`define BDWT_SSYN_NS 150
`define BDWT_MSYN_NS 150
`define BDWT_DSK_NS 75
`define BDWT_HOLD_NS 75
`define BDWT_INH_NS 100
`define BDWT_TMO_NS 20000
`define BDWT_SSYN_CYC `BDWT_CEIL(`BDWT_SSYN_NS)
`define BDWT_MSYN_CYC `BDWT_CEIL(`BDWT_MSYN_NS)
`define BDWT_DSK_CYC `BDWT_CEIL(`BDWT_DSK_NS)
`define BDWT_HOLD_CYC `BDWT_CEIL(`BDWT_HOLD_NS)
`define BDWT_INH_CYC `BDWT_CEIL(`BDWT_INH_NS)
`define BDWT_TMO_CYC `BDWT_CEIL(`BDWT_TMO_NS)
`define BDWT_SEL_CNT 2'h0
`define BDWT_SEL_PTR 2'h1
`define BDWT_SEL_CSR 2'h2
`define BDWT_SEL_BUF 2'h3
`define BDWT_ST_GO 0
`define BDWT_ST_FN 1
`define BDWT_ST_XLO 4
`define BDWT_ST_XHI 5
`define BDWT_ST_IE 6
`define BDWT_ST_RDY 7
`define BDWT_ST_CYC 8
`define BDWT_ST_DS 9
`define BDWT_ST_ALERT 13
`define BDWT_ST_NEX 14
`define BDWT_ST_ERR 15
`define BDWT_TOP_BITS 5'h1f
`endif

// >>> inc/bdwt_pkg.sv
package bdwt_pkg;
    typedef enum logic [2:0] {
        BDWT_IDLE = 3'b000,
        BDWT_SETUP = 3'b001,
        BDWT_WAIT = 3'b010,
        BDWT_DSK = 3'b011,
        BDWT_HOLD = 3'b100
    } bdwt_mst_t;
    typedef logic [15:0] bdwt_word_t;
endpackage

// >>> inc/bdwt_tmr_if.sv
interface bdwt_tmr_if #(parameter int W = 10);
    logic ld;
    logic [W-1:0] val;
    logic done;
    modport ctl (output ld, output val, input done);
    modport tmr (input ld, input val, output done);
endinterface

// >>> logic/bdwt_sync.sv
module bdwt_sync #(parameter int W = 8) (
    // clock
    input wire logic i_clk,
    // level in and synchronised level out
    input wire logic [W-1:0] i_d,
    output logic [W-1:0] o_q
);
    logic [W-1:0] s1_r;
    logic [W-1:0] s2_r;
    // two flops per bit, first read only by second
    always_ff @(posedge i_clk) begin
        s1_r <= i_d;
        s2_r <= s1_r;
    end
    assign o_q = s2_r;
endmodule

// >>> logic/bdwt_timer.sv
module bdwt_timer #(parameter int W = 10) (
    // clock and reset
    input wire logic i_clk,
    input wire logic i_rst,
    // load and done
    bdwt_tmr_if.tmr t
);
    logic [W-1:0] cnt_r;
    // down counter, stops at zero
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            cnt_r <= {W{1'b0}};
        end else if (t.ld) begin
            cnt_r <= t.val;
        end else if (cnt_r != {W{1'b0}}) begin
            cnt_r <= cnt_r - W'(1);
        end
    end
    assign t.done = (cnt_r == {W{1'b0}});
endmodule

// >>> logic/bdwt_top.sv
// Local design decisions: the register offsets and register access over Wishbone.
`include "bdwt_params.svh"
module bdwt_top import bdwt_pkg::*; #(
    parameter logic [8:0] BASE = 9'h000,
    parameter logic [5:0] VEC_HI = 6'h00,
    parameter logic VEC_B2 = 1'b1
) (
    // clock and reset
    input wire logic I_CORE_CLK,
    input wire logic I_RESET,
    // wishbone slave
    input wire logic I_WB_CYC,
    input wire logic I_WB_STB,
    input wire logic I_WB_WE,
    input wire logic [17:0] I_WB_ADR,
    input wire logic [1:0] I_WB_SEL,
    input wire logic [15:0] I_WB_DAT,
    output logic O_WB_ACK,
    output logic O_WB_ERR,
    output logic [15:0] O_WB_DAT,
    // system bus master side
    input wire logic I_BUS_SSYN,
    input wire logic I_BUS_NPG,
    input wire logic I_BUS_BG,
    input wire logic [15:0] I_BUS_DAT,
    output logic [15:0] O_BUS_DAT,
    output logic O_BUS_DAT_OE,
    output logic [17:0] O_BUS_ADR,
    output logic O_BUS_ADR_OE,
    output logic [1:0] O_BUS_C,
    output logic O_BUS_MSYN,
    output logic O_BUS_NPR,
    output logic O_BUS_BBSY,
    output logic O_BUS_BR,
    output logic O_BUS_INTR,
    // user device inputs
    input wire logic [15:0] I_USR_DAT,
    input wire logic [1:0] I_USR_C,
    input wire logic I_USR_REQ_A,
    input wire logic I_USR_REQ_B,
    input wire logic I_USR_WC_EN,
    input wire logic I_USR_BA_EN,
    input wire logic I_USR_A00,
    input wire logic [2:0] I_USR_STAT,
    input wire logic I_USR_ALERT,
    input wire logic I_USR_SINGLE,
    // user device outputs
    output logic [15:0] O_USR_DAT,
    output logic [2:0] O_USR_FNCT,
    output logic O_USR_READY,
    output logic O_USR_BUSY,
    output logic O_USR_END,
    output logic O_USR_GO
);
    localparam int TW = 10;

    // address decode helpers
    function automatic logic dec_hit(input logic [17:0] a);
        return (a[17:13] == `BDWT_TOP_BITS) && (a[12:4] == BASE) && (a[3] | a[2]);
    endfunction
    function automatic logic [1:0] dec_sel(input logic [17:0] a);
        return a[2:1];
    endfunction

    // synchronised pins
    logic [46:0] raw_w;
    logic [46:0] syn_w;
    assign raw_w = {I_BUS_DAT, I_USR_DAT, I_BUS_SSYN, I_BUS_NPG, I_BUS_BG,
                    I_USR_REQ_A, I_USR_REQ_B, I_USR_C, I_USR_WC_EN, I_USR_BA_EN,
                    I_USR_A00, I_USR_STAT, I_USR_ALERT, I_USR_SINGLE};
    bdwt_sync #(.W(47)) u_sync (.i_clk(I_CORE_CLK), .i_d(raw_w), .o_q(syn_w));
    wire [15:0] bdat_s = syn_w[46:31];
    wire [15:0] udat_s = syn_w[30:15];
    wire ssyn_s = syn_w[14];
    wire npg_s = syn_w[13];
    wire bg_s = syn_w[12];
    wire req_s = syn_w[11] | syn_w[10];
    wire [1:0] uc_s = syn_w[9:8];
    wire wc_en_s = syn_w[7];
    wire ba_en_s = syn_w[6];
    wire a00_s = syn_w[5];
    wire [2:0] stat_s = syn_w[4:2];
    wire alert_s = syn_w[1];
    wire single_s = syn_w[0];

    // timers
    bdwt_tmr_if #(.W(TW)) mt ();
    bdwt_tmr_if #(.W(TW)) it ();
    bdwt_timer #(.W(TW)) u_mtmr (.i_clk(I_CORE_CLK), .i_rst(I_RESET), .t(mt));
    bdwt_timer #(.W(TW)) u_itmr (.i_clk(I_CORE_CLK), .i_rst(I_RESET), .t(it));

    // registers
    bdwt_word_t cnt_r;
    bdwt_word_t ptr_r;
    bdwt_word_t buf_r;
    logic [2:0] fnct_r;
    logic xlo_r, xhi_r, ie_r, ready_r, cycle_r, nex_r, pwrap_r;
    logic ack_r, err_r;
    logic [15:0] wdat_r;
    logic [2:0] sl_cnt_r;
    logic go_r, end_r, req_d_r, err_d_r;
    logic master_r, npr_r, br_r, intr_r, int_done_r;
    logic msyn_r, adr_oe_r, doe_r;
    logic [17:0] adr_r;
    logic [1:0] c_r;
    logic [15:0] dout_r;
    bdwt_mst_t st_r;
    bdwt_mst_t st_nxt;

    // slave decode and strobes
    wire wb_req = I_WB_CYC & I_WB_STB;
    wire pend = wb_req & ~ack_r & ~err_r;
    wire hit = dec_hit(I_WB_ADR);
    wire [1:0] rsel = dec_sel(I_WB_ADR);
    wire fire = pend & hit & (sl_cnt_r == 3'(`BDWT_SSYN_CYC - 1));
    wire ld_lo = fire & I_WB_WE & I_WB_SEL[0];
    wire ld_hi = fire & I_WB_WE & I_WB_SEL[1];
    wire ld_any = ld_lo | ld_hi;
    wire ld_cnt = ld_any & I_WB_ADR[3] & (rsel == `BDWT_SEL_CNT);
    wire ld_ptr = ld_any & I_WB_ADR[3] & (rsel == `BDWT_SEL_PTR);
    wire ld_csr = rsel == `BDWT_SEL_CSR;
    wire ld_buf = ld_any & (rsel == `BDWT_SEL_BUF);
    wire go_w = ld_lo & ld_csr & I_WB_DAT[`BDWT_ST_GO];

    // status word and read mux
    wire err_w = nex_r | alert_s | pwrap_r;
    logic [15:0] csr_w;
    assign csr_w = {err_w, nex_r, alert_s, 1'b0, stat_s, cycle_r, ready_r, ie_r,
                    xhi_r, xlo_r, fnct_r, 1'b0};
    logic [15:0] rd_mux;
    always_comb begin
        unique case (rsel)
            `BDWT_SEL_CNT: rd_mux = cnt_r;
            `BDWT_SEL_PTR: rd_mux = {ptr_r[15:1], a00_s};
            `BDWT_SEL_CSR: rd_mux = csr_w;
            `BDWT_SEL_BUF: rd_mux = udat_s;
        endcase
    end

    // wishbone answer
    always_ff @(posedge I_CORE_CLK) begin
        if (I_RESET) begin
            ack_r <= 1'b0;
            err_r <= 1'b0;
            sl_cnt_r <= 3'h0;
            wdat_r <= 16'h0000;
        end else begin
            ack_r <= fire;
            err_r <= pend & ~hit;
            sl_cnt_r <= pend & hit ? sl_cnt_r + 3'h1 : 3'h0;
            if (fire) begin
                wdat_r <= I_WB_WE ? 16'h0000 : rd_mux;
            end
        end
    end

    // master sequencer
    wire start = cycle_r & master_r & ~ssyn_s & ~ready_r;
    wire is_wr = c_r[1];
    wire step = (st_r == BDWT_HOLD) & mt.done;
    wire wc_wrap = step & wc_en_s & (cnt_r == 16'hffff);
    always_comb begin
        st_nxt = st_r;
        mt.ld = 1'b0;
        mt.val = TW'(0);
        unique case (st_r)
            BDWT_IDLE: if (start) begin
                st_nxt = BDWT_SETUP;
                mt.ld = 1'b1;
                mt.val = TW'(`BDWT_MSYN_CYC - 1);
            end
            BDWT_SETUP: if (mt.done) begin
                st_nxt = BDWT_WAIT;
                mt.ld = 1'b1;
                mt.val = TW'(`BDWT_TMO_CYC - 1);
            end
            BDWT_WAIT: if (ssyn_s & ~is_wr) begin
                st_nxt = BDWT_DSK;
                mt.ld = 1'b1;
                mt.val = TW'(`BDWT_DSK_CYC - 1);
            end else if (ssyn_s | mt.done) begin
                st_nxt = BDWT_HOLD;
                mt.ld = 1'b1;
                mt.val = TW'(`BDWT_HOLD_CYC - 1);
            end
            BDWT_DSK: if (mt.done) begin
                st_nxt = BDWT_HOLD;
                mt.ld = 1'b1;
                mt.val = TW'(`BDWT_HOLD_CYC - 1);
            end
            BDWT_HOLD: if (mt.done) begin
                st_nxt = BDWT_IDLE;
            end
            default: st_nxt = BDWT_IDLE;
        endcase
    end

    // master outputs
    always_ff @(posedge I_CORE_CLK) begin
        if (I_RESET) begin
            st_r <= BDWT_IDLE;
            msyn_r <= 1'b0;
            adr_oe_r <= 1'b0;
            doe_r <= 1'b0;
            c_r <= 2'h0;
            adr_r <= 18'h00000;
            end_r <= 1'b0;
        end else begin
            st_r <= st_nxt;
            end_r <= step;
            if (st_r == BDWT_IDLE && start) begin
                adr_oe_r <= 1'b1;
                c_r <= uc_s;
                adr_r <= {xhi_r, xlo_r, ptr_r[15:1], a00_s};
                doe_r <= uc_s[1];
            end else if (step) begin
                adr_oe_r <= 1'b0;
                doe_r <= 1'b0;
            end
            if (st_r == BDWT_SETUP && mt.done) begin
                msyn_r <= 1'b1;
            end else if (st_nxt == BDWT_HOLD && st_r != BDWT_HOLD) begin
                msyn_r <= 1'b0;
            end
        end
    end

    // user data onto the bus; vector loaded on the grant so it stands from the first intr cycle
    always_ff @(posedge I_CORE_CLK) begin
        if (I_RESET) begin
            dout_r <= 16'h0000;
        end else if (intr_r | (br_r & bg_s)) begin
            dout_r <= {7'h00, VEC_HI, VEC_B2, 2'h0};
        end else begin
            dout_r <= udat_s;
        end
    end

    // bus request and mastership
    wire want = (cycle_r | ~single_s) & ~ready_r;
    always_ff @(posedge I_CORE_CLK) begin
        if (I_RESET) begin
            npr_r <= 1'b0;
            master_r <= 1'b0;
        end else begin
            npr_r <= want & ~master_r;
            if (npr_r & npg_s & want) begin
                master_r <= 1'b1;
            end else if (~want & st_r == BDWT_IDLE & ~end_r) begin
                master_r <= 1'b0;
            end
        end
    end

    // software registers and flags
    always_ff @(posedge I_CORE_CLK) begin
        if (I_RESET) begin
            cnt_r <= 16'h0000;
            ptr_r <= 16'h0000;
            buf_r <= 16'h0000;
            fnct_r <= 3'h0;
            {xlo_r, xhi_r, ie_r, nex_r, pwrap_r, cycle_r} <= 6'h00;
            ready_r <= 1'b1;
            go_r <= 1'b0;
            req_d_r <= 1'b0;
            err_d_r <= 1'b0;
        end else begin
            req_d_r <= req_s;
            err_d_r <= err_w;
            go_r <= go_w;
            if (ld_cnt) begin
                cnt_r <= I_WB_DAT;
            end else if (step & wc_en_s) begin
                cnt_r <= cnt_r + 16'h0001;
            end
            if (ld_ptr) begin
                ptr_r <= I_WB_DAT;
            end else if (step & ba_en_s) begin
                ptr_r <= ptr_r + 16'h0002;
            end
            if (step & ba_en_s & ptr_r[15:1] == 15'h7fff) begin
                pwrap_r <= 1'b1;
            end else if (ld_ptr) begin
                pwrap_r <= 1'b0;
            end
            if (st_r == BDWT_DSK && mt.done) begin
                buf_r <= bdat_s;
            end else if (ld_buf) begin
                buf_r <= I_WB_DAT;
            end
            if (ld_lo & ld_csr) begin
                fnct_r <= I_WB_DAT[`BDWT_ST_FN +: 3];
                xlo_r <= I_WB_DAT[`BDWT_ST_XLO];
                xhi_r <= I_WB_DAT[`BDWT_ST_XHI];
                ie_r <= I_WB_DAT[`BDWT_ST_IE];
            end
            if (st_r == BDWT_WAIT && mt.done && ~ssyn_s) begin
                nex_r <= 1'b1;
            end else if (ld_hi & ld_csr & ~I_WB_DAT[`BDWT_ST_NEX]) begin
                nex_r <= 1'b0;
            end
            if (req_d_r & ~req_s) begin
                cycle_r <= 1'b1;
            end else if (end_r) begin
                cycle_r <= 1'b0;
            end else if (ld_hi & ld_csr) begin
                cycle_r <= I_WB_DAT[`BDWT_ST_CYC];
            end
            if (err_w | wc_wrap) begin
                ready_r <= 1'b1;
            end else if (go_w) begin
                ready_r <= 1'b0;
            end
        end
    end

    // interrupt request, hold-off after go or a new error
    assign it.ld = go_w | (err_w & ~err_d_r);
    assign it.val = TW'(`BDWT_INH_CYC - 1);
    wire inh = ~it.done | it.ld;
    wire irq_cond = ie_r & ready_r & ~inh;
    always_ff @(posedge I_CORE_CLK) begin
        if (I_RESET) begin
            br_r <= 1'b0;
            intr_r <= 1'b0;
            int_done_r <= 1'b0;
        end else begin
            br_r <= irq_cond & ~int_done_r & ~intr_r & ~(br_r & bg_s);
            if (br_r & bg_s) begin
                intr_r <= 1'b1;
            end else if (intr_r & ssyn_s) begin
                intr_r <= 1'b0;
            end
            if (intr_r & ssyn_s) begin
                int_done_r <= 1'b1;
            end else if (~irq_cond) begin
                int_done_r <= 1'b0;
            end
        end
    end

    // port drive
    assign O_WB_ACK = ack_r;
    assign O_WB_ERR = err_r;
    assign O_WB_DAT = wdat_r;
    assign O_BUS_DAT = dout_r;
    assign O_BUS_DAT_OE = doe_r | intr_r;
    assign O_BUS_ADR = adr_r;
    assign O_BUS_ADR_OE = adr_oe_r;
    assign O_BUS_C = c_r;
    assign O_BUS_MSYN = msyn_r;
    assign O_BUS_NPR = npr_r;
    assign O_BUS_BBSY = master_r;
    assign O_BUS_BR = br_r;
    assign O_BUS_INTR = intr_r;
    assign O_USR_DAT = buf_r;
    assign O_USR_FNCT = fnct_r;
    assign O_USR_READY = ready_r;
    assign O_USR_BUSY = cycle_r;
    assign O_USR_END = end_r;
    assign O_USR_GO = go_r;

    // checks
    default clocking @(posedge I_CORE_CLK); endclocking
    default disable iff (I_RESET);
    sequence s_drive; $rose(adr_oe_r); endsequence
    sequence s_setup; !msyn_r [*4] ##1 msyn_r; endsequence
    AST_ACK_DLY: assert property ($rose(wb_req) && hit |-> ##4 ack_r)
        else $error("slave reply delay wrong");
    AST_MSYN: assert property (s_drive |-> s_setup)
        else $error("master sync setup wrong");
    AST_START: assert property (s_drive |-> $past(cycle_r && master_r && !ssyn_s))
        else $error("cycle started without conditions");
    AST_HOLD: assert property ($fell(msyn_r) |-> adr_oe_r [*2] ##1 !adr_oe_r)
        else $error("drive removal timing wrong");
    AST_RDOE: assert property (adr_oe_r && !c_r[1] |-> !doe_r)
        else $error("data driven on read cycle");
    AST_NPR: assert property (ready_r |=> !npr_r)
        else $error("transfer request while ready");
    AST_BR: assert property ($rose(br_r) |-> $past(ie_r && ready_r))
        else $error("interrupt request without cause");
    AST_GO: assert property (go_w && !err_w && !wc_wrap |=> !ready_r ##1 go_r == 1'b0)
        else $error("go did not clear ready");
    AST_WRAP: assert property (wc_wrap |=> ready_r && cnt_r == 16'h0000 && end_r)
        else $error("count wrap did not set ready");
endmodule

// >>> sim/bdwt_bus_model.sv
module bdwt_bus_model #(parameter logic [15:0] RD = 16'hbeef) (
    // clock and reset
    input wire logic i_clk,
    input wire logic i_rst,
    // requests from the block
    input wire logic i_msyn,
    input wire logic i_intr,
    input wire logic i_npr,
    input wire logic i_br,
    input wire logic i_dat_oe,
    input wire logic [15:0] i_dat,
    input wire logic [17:0] i_adr,
    input wire logic [1:0] i_c,
    // replies to the block
    output logic o_ssyn,
    output logic o_npg,
    output logic o_bg,
    output logic [15:0] o_dat
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [1:0] dly;
    logic [15:0] last;
    logic [17:0] cap_adr;
    logic [15:0] cap_dat;
    logic [1:0] cap_c;
    // data wire level: block drive, slave read word, else a changing pattern
    assign o_dat = i_dat_oe ? i_dat : (o_ssyn ? RD : ~last);
    // grants follow requests; slave reply after a delay, held until sync drops
    always @(posedge i_clk) begin
        if (i_rst) begin
            o_ssyn <= 1'b0;
            o_npg <= 1'b0;
            o_bg <= 1'b0;
            dly <= 2'h0;
            last <= 16'h0;
        end else begin
            o_npg <= i_npr;
            o_bg <= i_br & ~i_intr;
            if ((i_msyn | i_intr) && dly == 2'h0) begin
                cap_adr <= i_adr;
                cap_c <= i_c;
                cap_dat <= o_dat;
            end
            dly <= (i_msyn | i_intr) ? ((dly == 2'h3) ? dly : dly + 2'h1) : 2'h0;
            o_ssyn <= (i_msyn | i_intr) & (o_ssyn | dly == 2'h2);
            last <= o_dat;
        end
    end
endmodule

// >>> sim/bdwt_top_test.sv
module bdwt_top_test;
    timeunit 1ns;
    timeprecision 1ns;
    localparam logic [8:0] BASE = 9'h0a5;
    localparam logic [5:0] VEC_HI = 6'h2a;
    localparam logic VEC_B2 = 1'b0;
    localparam logic [13:0] PFX = {5'h1f, BASE};
    logic clk = 1'b0, rst = 1'b1, cyc = 1'b0, stb = 1'b0, we = 1'b0;
    logic [17:0] adr = '0;
    logic [1:0] sel = '0, uc = '0;
    logic [15:0] wdat = '0, udat = '0, q;
    logic reqa = 1'b0, alert = 1'b0, single = 1'b1, e;
    logic [2:0] ust = 3'h5;
    wire ack, err, oe, aoe, msyn, npr, bbsy, br, intr, ssyn, npg, bg, rdy, busy, uend, go;
    wire [15:0] rdat, bdo, bdi, uo;
    wire [17:0] badr;
    wire [1:0] bc;
    wire [2:0] fn;
    int error_cnt = 0, n_tests = 0, n_go = 0, n_bad = 0;
    logic [1:0] ct [4] = '{2'b10, 2'b11, 2'b01, 2'b00};

    always #20 clk = ~clk;

    // count go pulses, and master cycles whose drive does not match the cycle type
    always @(posedge clk) begin
        if (go === 1'b1) n_go++;
        if (msyn === 1'b1 && {bbsy, aoe, oe} !== {2'b11, bc[1]}) n_bad++;
    end

    bdwt_top #(.BASE(BASE), .VEC_HI(VEC_HI), .VEC_B2(VEC_B2)) dut (
        .I_CORE_CLK(clk), .I_RESET(rst), .I_WB_CYC(cyc), .I_WB_STB(stb), .I_WB_WE(we),
        .I_WB_ADR(adr), .I_WB_SEL(sel), .I_WB_DAT(wdat), .O_WB_ACK(ack), .O_WB_ERR(err),
        .O_WB_DAT(rdat), .I_BUS_SSYN(ssyn), .I_BUS_NPG(npg), .I_BUS_BG(bg), .I_BUS_DAT(bdi),
        .O_BUS_DAT(bdo), .O_BUS_DAT_OE(oe), .O_BUS_ADR(badr), .O_BUS_ADR_OE(aoe),
        .O_BUS_C(bc), .O_BUS_MSYN(msyn), .O_BUS_NPR(npr), .O_BUS_BBSY(bbsy), .O_BUS_BR(br),
        .O_BUS_INTR(intr), .I_USR_DAT(udat), .I_USR_C(uc), .I_USR_REQ_A(reqa),
        .I_USR_REQ_B(1'b0), .I_USR_WC_EN(1'b1), .I_USR_BA_EN(1'b1), .I_USR_A00(1'b0),
        .I_USR_STAT(ust), .I_USR_ALERT(alert), .I_USR_SINGLE(single), .O_USR_DAT(uo),
        .O_USR_FNCT(fn), .O_USR_READY(rdy), .O_USR_BUSY(busy), .O_USR_END(uend),
        .O_USR_GO(go));

    bdwt_bus_model mdl (
        .i_clk(clk), .i_rst(rst), .i_msyn(msyn), .i_intr(intr), .i_npr(npr), .i_br(br),
        .i_dat_oe(oe), .i_dat(bdo), .i_adr(badr), .i_c(bc), .o_ssyn(ssyn), .o_npg(npg),
        .o_bg(bg), .o_dat(bdi));

    // compare one result and count it
    task chk(input logic [17:0] got, input logic [17:0] exp);
        n_tests++;
        if (got !== exp) begin
            error_cnt++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // one classic bus cycle, held until ack or err
    task wb(input logic w, input logic [17:0] a, input logic [1:0] s, input logic [15:0] d);
        int k;
        @(posedge clk);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        sel <= s;
        wdat <= d;
        k = 0;
        do begin
            @(posedge clk);
            k++;
        end while (ack !== 1'b1 && err !== 1'b1 && k < 50);
        if (k >= 50) error_cnt++;
        q = rdat;
        e = err;
        cyc <= 1'b0;
        stb <= 1'b0;
    endtask

    // user side: set type and data, pulse a request, wait for the end pulse
    task usr_cycle(input logic [1:0] c, input logic [15:0] d);
        int k;
        @(posedge clk);
        uc <= c;
        udat <= d;
        reqa <= 1'b1;
        repeat (4) @(posedge clk);
        reqa <= 1'b0;
        k = 0;
        do begin
            @(posedge clk);
            k++;
        end while (uend !== 1'b1 && k < 2000);
        if (k >= 2000) error_cnt++;
        repeat (3) @(posedge clk);
    endtask

    task print_verdict;
        $display("errors %0d checks %0d", error_cnt, n_tests);
        if (error_cnt == 0 && n_tests > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask

    initial begin
        #(40 * 40000);
        error_cnt++;
        print_verdict();
    end

    // main sequence
    initial begin
        repeat (10) @(posedge clk);
        rst <= 1'b0;
        wb(1'b0, {PFX, 4'h4}, 2'b11, 16'h0);
        chk(q[7], 1'b1);
        chk(q[11:9], 3'h5);
        wb(1'b1, {PFX, 4'h8}, 2'b01, 16'hfffc);
        wb(1'b0, {PFX, 4'h8}, 2'b11, 16'h0);
        chk(q, 16'hfffc);
        wb(1'b1, {PFX, 4'ha}, 2'b10, 16'h0100);
        wb(1'b0, {PFX, 4'ha}, 2'b11, 16'h0);
        chk(q, 16'h0100);
        wb(1'b1, 18'h00008, 2'b11, 16'h1);
        chk(e, 1'b1);
        chk(npr, 1'b0);
        wb(1'b1, {PFX, 4'h4}, 2'b01, 16'h005b);
        repeat (4) @(posedge clk);
        chk(rdy, 1'b0);
        chk(fn, 3'h5);
        // burst hold: bus taken with no cycle pending, given back when the input rises
        single <= 1'b0;
        repeat (12) @(posedge clk);
        chk(bbsy, 1'b1);
        single <= 1'b1;
        repeat (8) @(posedge clk);
        chk(bbsy, 1'b0);
        // every cycle type on stepping addresses, last one wraps the count
        for (int i = 0; i < 4; i++) begin
            usr_cycle(ct[i], 16'h1230 + 16'(i));
            chk(mdl.cap_adr, 18'h10100 + 18'(2 * i));
            chk(mdl.cap_c, ct[i]);
            if (ct[i][1]) chk(mdl.cap_dat, 16'h1230 + 16'(i));
            else chk(uo, 16'hbeef);
            chk(busy, 1'b0);
            chk(bbsy, 1'b0);
            chk(rdy, i == 3);
        end
        repeat (20) @(posedge clk);
        chk(mdl.cap_dat[8:0], {VEC_HI, VEC_B2, 2'b00});
        wb(1'b0, {PFX, 4'ha}, 2'b11, 16'h0);
        chk(q, 16'h0108);
        wb(1'b0, {PFX, 4'h8}, 2'b11, 16'h0);
        chk(q, 16'h0000);
        alert <= 1'b1;
        ust <= 3'h2;
        repeat (6) @(posedge clk);
        wb(1'b0, {PFX, 4'h4}, 2'b11, 16'h0);
        chk(q & 16'ha080, 16'ha080);
        chk(q[11:9], 3'h2);
        chk(npr, 1'b0);
        chk(18'(n_go), 18'h00001);
        chk(18'(n_bad), 18'h00000);
        print_verdict();
    end
endmodule
